// ### pkg/cca_pkg.sv
/*
  Shared constants of the counter array: register map, field
  positions, reset values and timebase codes.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
// Notes on behaviour
// - Full 16-bit wrap sets counter overflow flag
// - Cycle overflow flag from bit 8/9/10/11
// - Flags always set; enables gate request only
// - All modules share one cycle length; PWM only at 8 bits
// - Comparator off: toggles hold, PWM drives low
// - Reload select steers module low and high byte addresses
// - Capture copies counter, sets module event flag
// - Module event flag cleared only by software
// - Pin level needs two stable clocks
// - Pin level readable after dual-edge capture
// - Software timer flags full 16-bit match
// - Low write clears, high write sets comparator
// - High-speed output toggles pin on match
// - Frequency mode toggles, adds high to low
// - Frequency mode select; optional 16-bit flag
// - 8-bit PWM high on match, low on wrap unless high byte is zero
// - 8-bit PWM reloads low from high on wrap
// - 8-bit PWM select, match flag, 256-tick overflow
// - Timebase select picks the counter tick
// - Counter wrap to zero sets overflow flag
package cca_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_MODE    = 8'h04;
  localparam logic [7:0] A_PWMC    = 8'h08;
  localparam logic [7:0] A_CNTL    = 8'h0C;
  localparam logic [7:0] A_CNTH    = 8'h10;
  localparam logic [7:0] A_PINS    = 8'h14;
  localparam logic [3:0] CH_BASE   = 4'h2;
  localparam logic [3:0] CH_MODE   = 4'h0;
  localparam logic [3:0] CH_LOW    = 4'h4;
  localparam logic [3:0] CH_HIGH   = 4'h8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_CF    = 7;
  localparam int B_CYCLE_OVERFLOW_FLAG  = 6;
  localparam int B_RUN   = 4;
  localparam int B_ECF   = 0;
  localparam int B_TBS   = 1;
  localparam int B_RELOAD_REGISTER_SELECT = 7;
  localparam int B_CYCLE_OVERFLOW_IRQ_ENABLE  = 6;
  localparam int B_ECOM  = 6;
  localparam int B_CAPP  = 5;
  localparam int B_CAPN  = 4;
  localparam int B_MAT   = 3;
  localparam int B_TOG   = 2;
  localparam int B_PWM   = 1;
  localparam int B_ECCF  = 0;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [7:0]  LOW_MAX  = 8'hFF;
  localparam logic [3:0]  DIV12    = 4'hB;
  localparam logic [1:0]  DIV4     = 2'h3;

  // ****************************************
  // Timebase codes
  // ****************************************
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4  = 3'h1;
  localparam logic [2:0] TB_T0OV  = 3'h2;
  localparam logic [2:0] TB_EXT   = 3'h3;
  localparam logic [2:0] TB_SYS   = 3'h4;
  localparam logic [2:0] TB_OSC8  = 3'h5;
  localparam logic [2:0] TB_RTC8  = 3'h6;

endpackage

// ### hw/cca_channel.sv
/*
  One capture/compare module: pin filter, capture, compare,
  toggle, frequency and 8-bit PWM output.
  Assumes the counter and the "counter just moved" pulse come
  from the shared counter array.
*/
`timescale 1ns/1ns
module cca_channel (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Shared counter
  input  wire logic        upd,
  input  wire logic [15:0] cnt,
  input  wire logic        pwm8_on,
  // Mode bits
  input  wire logic        ecom,
  input  wire logic        capp,
  input  wire logic        capn,
  input  wire logic        mat,
  input  wire logic        tog,
  input  wire logic        pwm,
  // Register writes
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wdata,
  // Pin and results
  input  wire logic        pin_in,
  output logic      [15:0] cp,
  output logic             pin_out,
  output logic             pin_lvl,
  output logic             evt
);
  import cca_pkg::*;

  logic s_q, prev_q, rise, fall, cap_hit;
  logic m16, m8, wrap8;
  logic is_cap, is_tmr, is_hso, is_frq, is_pw8;

  // Level only accepted once two samples agree
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q     <= 1'b0;
      pin_lvl <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      s_q    <= pin_in;
      prev_q <= pin_lvl;
      if (pin_in == s_q) pin_lvl <= s_q;
    end
  end

  assign rise    = pin_lvl & ~prev_q;
  assign fall    = ~pin_lvl & prev_q;
  assign is_cap  = ~tog & ~pwm;
  assign cap_hit = is_cap & ((capp & rise) | (capn & fall));
  assign is_tmr  = ecom & mat & ~tog & ~pwm;
  assign is_hso  = ecom & mat & tog & ~pwm;
  assign is_frq  = ecom & tog & pwm;
  assign is_pw8  = pwm & ~tog & pwm8_on;
  // Compare only right after the counter moved
  assign m16     = upd & (cnt == cp);
  assign m8      = upd & (cnt[7:0] == cp[7:0]);
  assign wrap8   = upd & (cnt[7:0] == RST_BYTE);

  assign evt = cap_hit
             | ((is_tmr | is_hso) & m16)
             | (is_frq & mat & m16)
             | (is_pw8 & ecom & mat & m8);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cp <= RST_WORD;
    end else if (wr_lo | wr_hi) begin
      if (wr_lo) cp[7:0] <= wdata;
      if (wr_hi) cp[15:8] <= wdata;
    end else if (cap_hit) begin
      cp <= cnt;
    end else if (is_frq & m8) begin
      cp[7:0] <= cp[7:0] + cp[15:8];
    end else if (is_pw8 & ecom & wrap8) begin
      cp[7:0] <= cp[15:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pin_out <= 1'b0;
    end else if (pwm & ~tog) begin
      if (!ecom || !is_pw8) pin_out <= 1'b0;
      else if (wrap8) pin_out <= (cp[15:8] == RST_BYTE);
      else if (m8) pin_out <= 1'b1;
    end else if ((is_hso & m16) | (is_frq & m8)) begin
      pin_out <= ~pin_out;
    end
  end

endmodule

// ### hw/counter_array_capture_compare.sv
/*
  Counter array with three capture/compare modules, its event
  flags and a classic Wishbone register slave.
  Assumes one 100 MHz clock, synchronous inputs, and that the
  processor gates irq_request with its own global enables.
*/
`timescale 1ns/1ns
module counter_array_capture_compare #(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Timebase sources
  input  wire logic              timer0_ovf_tick,
  input  wire logic              ext_osc_tick,
  input  wire logic              rtc_osc_tick,
  input  wire logic              external_count_input,
  // Module pins
  input  wire logic [NUM_CH-1:0] module_io_in,
  output logic      [NUM_CH-1:0] module_io_out,
  output logic      [NUM_CH-1:0] module_io_oe_n,
  // Interrupt request to processor
  output logic                   irq_request
);
  import cca_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] cnt_q;
  logic        run_q;
  logic        upd_q;
  logic        cf_q;
  logic        cycle_overflow_flag_q;
  logic [NUM_CH-1:0] ccf_q;
  logic        ecf_q;
  logic [2:0]  tbs_q;
  logic        reload_register_select_q;
  logic        cycle_overflow_irq_enable_q;
  logic [1:0]  cycle_length_select_q;
  logic [7:0]  mode_q [NUM_CH];
  logic [15:0] arl_q  [NUM_CH];
  logic [3:0]  div_q;
  logic        eci_q;
  logic        tick_c;
  logic        step;
  logic        cyc_wrap;
  logic [15:0] cp_w   [NUM_CH];
  logic [NUM_CH-1:0] evt_w;
  logic [NUM_CH-1:0] lvl_w;
  logic [NUM_CH-1:0] wr_lo;
  logic [NUM_CH-1:0] wr_hi;
  logic [NUM_CH-1:0] wr_md;
  logic        bus_rd;
  logic        bus_wr;
  logic [7:0]  wd;
  logic [3:0]  ch_off;
  logic        ch_hit;
  logic [31:0] rd_d;
  logic        irq_d;
  logic        wr_ctrl;
  logic        wr_cntl;
  logic        wr_cnth;

  // ****************************************
  // Bus decode
  // ****************************************
  // Reads sample on the request edge, writes on the ack edge
  assign bus_rd = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o
                & wb_we_i & wb_sel_i[0];
  // Byte writes need sel[0]; upper lanes carry nothing
  assign wd     = wb_dat_i[7:0];
  // Named targets keep the register blocks short
  assign wr_ctrl = bus_wr & (wb_adr_i == A_CTRL);
  assign wr_cntl = bus_wr & (wb_adr_i == A_CNTL);
  assign wr_cnth = bus_wr & (wb_adr_i == A_CNTH);
  assign ch_off = wb_adr_i[7:4] - CH_BASE;
  assign ch_hit = (wb_adr_i[7:4] >= CH_BASE)
                & (32'(ch_off) < NUM_CH);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      wr_md[i] = bus_wr & ch_hit & (32'(ch_off) == i)
               & (wb_adr_i[3:0] == CH_MODE);
      wr_lo[i] = bus_wr & ch_hit & (32'(ch_off) == i)
               & (wb_adr_i[3:0] == CH_LOW);
      wr_hi[i] = bus_wr & ch_hit & (32'(ch_off) == i)
               & (wb_adr_i[3:0] == CH_HIGH);
    end
  end

  // ****************************************
  // Timebase
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_q <= 4'h0;
      eci_q <= 1'b0;
    end else begin
      // Twelve is a multiple of four, so div4 reuses this count
      div_q <= (div_q == DIV12) ? 4'h0 : div_q + 4'h1;
      eci_q <= external_count_input;
    end
  end

  always_comb begin
    case (tbs_q)
      TB_DIV12: tick_c = (div_q == DIV12);
      TB_DIV4:  tick_c = (div_q[1:0] == DIV4);
      TB_T0OV:  tick_c = timer0_ovf_tick;
      TB_EXT:   tick_c = eci_q & ~external_count_input;
      TB_SYS:   tick_c = 1'b1;
      TB_OSC8:  tick_c = ext_osc_tick;
      TB_RTC8:  tick_c = rtc_osc_tick;
      default:  tick_c = 1'b0;
    endcase
  end

  // A stopped counter ignores every tick source
  assign step = tick_c & run_q;
  // Low N bits all ones where N follows the shared length
  assign cyc_wrap = step & (cnt_q[7:0] == LOW_MAX)
                  & (cycle_length_select_q < 2'd1 | cnt_q[8])
                  & (cycle_length_select_q < 2'd2 | cnt_q[9])
                  & (cycle_length_select_q < 2'd3 | cnt_q[10]);

  // ****************************************
  // Counter
  // ****************************************
  // Software writes win over a tick in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= RST_WORD;
      upd_q <= 1'b0;
    end else begin
      // A written counter did not step, so nothing compares next cycle
      upd_q <= step & ~(wr_cntl | wr_cnth);
      if (wr_cntl) cnt_q[7:0] <= wd;
      else if (wr_cnth) cnt_q[15:8] <= wd;
      else if (step) cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // Control and mode registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_q   <= 1'b0;
      ecf_q   <= 1'b0;
      tbs_q   <= TB_DIV12;
      reload_register_select_q <= 1'b0;
      cycle_overflow_irq_enable_q  <= 1'b0;
      cycle_length_select_q <= 2'b00;
    end else if (bus_wr) begin
      if (wb_adr_i == A_CTRL) run_q <= wd[B_RUN];
      if (wb_adr_i == A_MODE) begin
        ecf_q <= wd[B_ECF];
        tbs_q <= wd[B_TBS+:3];
      end
      if (wb_adr_i == A_PWMC) begin
        reload_register_select_q <= wd[B_RELOAD_REGISTER_SELECT];
        cycle_overflow_irq_enable_q  <= wd[B_CYCLE_OVERFLOW_IRQ_ENABLE];
        cycle_length_select_q <= wd[1:0];
      end
    end
  end

  // Comparator enable follows byte writes to the module
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mode_q[i] <= RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_md[i]) mode_q[i] <= wd;
        else if (wr_lo[i]) mode_q[i][B_ECOM] <= 1'b0;
        else if (wr_hi[i]) mode_q[i][B_ECOM] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Reload storage
  // ****************************************

  // Reload bytes only hold data; the 9-11 bit PWM modes are absent
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        arl_q[i] <= RST_WORD;
      end
    end else if (reload_register_select_q) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_lo[i]) arl_q[i][7:0] <= wd;
        if (wr_hi[i]) arl_q[i][15:8] <= wd;
      end
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  // A set in the same cycle as a clear write is kept
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cf_q   <= 1'b0;
      cycle_overflow_flag_q <= 1'b0;
      ccf_q  <= '0;
    end else begin
      if (wr_ctrl) begin
        cf_q   <= wd[B_CF];
        cycle_overflow_flag_q <= wd[B_CYCLE_OVERFLOW_FLAG];
        ccf_q  <= wd[NUM_CH-1:0];
      end
      if (step && cnt_q == CNT_MAX) cf_q <= 1'b1;
      if (cyc_wrap) cycle_overflow_flag_q <= 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        if (evt_w[i]) ccf_q[i] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************

  // Held one cycle so the request leaves a flip-flop
  always_comb begin
    irq_d = (cf_q & ecf_q) | (cycle_overflow_flag_q & cycle_overflow_irq_enable_q);
    for (int i = 0; i < NUM_CH; i++) begin
      irq_d = irq_d | (ccf_q[i] & mode_q[i][B_ECCF]);
    end
  end

  // Request carries only the array enables; processor-side enables gate it
  always_ff @(posedge ref_clk) begin
    if (!nrst) irq_request <= 1'b0;
    else irq_request <= irq_d;
  end

  // ****************************************
  // Capture/compare modules
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    cca_channel u_ch (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .upd     (upd_q),
      .cnt     (cnt_q),
      .pwm8_on (cycle_length_select_q == 2'b00),
      .ecom    (mode_q[g][B_ECOM]),
      .capp    (mode_q[g][B_CAPP]),
      .capn    (mode_q[g][B_CAPN]),
      .mat     (mode_q[g][B_MAT]),
      .tog     (mode_q[g][B_TOG]),
      .pwm     (mode_q[g][B_PWM]),
      .wr_lo   (wr_lo[g] & ~reload_register_select_q),
      .wr_hi   (wr_hi[g] & ~reload_register_select_q),
      .wdata   (wd),
      .pin_in  (module_io_in[g]),
      .cp      (cp_w[g]),
      .pin_out (module_io_out[g]),
      .pin_lvl (lvl_w[g]),
      .evt     (evt_w[g])
    );
  end

  // ****************************************
  // Pin drive enables
  // ****************************************

  // Output modes drive the pin; capture modes leave it free
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      module_io_oe_n <= '1;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        module_io_oe_n[i] <= ~(mode_q[i][B_TOG] | mode_q[i][B_PWM]);
      end
    end
  end

  // ****************************************
  // Read data and acknowledge
  // ****************************************
  always_comb begin
    rd_d = 32'h00000000;
    case (wb_adr_i)
      A_CTRL: begin
        rd_d[B_CF]         = cf_q;
        rd_d[B_CYCLE_OVERFLOW_FLAG]       = cycle_overflow_flag_q;
        rd_d[B_RUN]        = run_q;
        rd_d[NUM_CH-1:0]   = ccf_q;
      end
      A_MODE: begin
        rd_d[B_ECF]        = ecf_q;
        rd_d[B_TBS+:3]     = tbs_q;
      end
      A_PWMC: begin
        rd_d[B_RELOAD_REGISTER_SELECT]      = reload_register_select_q;
        rd_d[B_CYCLE_OVERFLOW_IRQ_ENABLE]       = cycle_overflow_irq_enable_q;
        rd_d[1:0]          = cycle_length_select_q;
      end
      A_CNTL: rd_d[7:0]    = cnt_q[7:0];
      A_CNTH: rd_d[7:0]    = cnt_q[15:8];
      A_PINS: begin
        rd_d[NUM_CH-1:0]   = lvl_w;
        rd_d[NUM_CH+3:4]   = module_io_out;
      end
      // Module bytes decode last; fixed registers take priority
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (ch_hit && 32'(ch_off) == i) begin
            case (wb_adr_i[3:0])
              CH_MODE: rd_d[7:0] = mode_q[i];
              CH_LOW:  rd_d[7:0] = reload_register_select_q ? arl_q[i][7:0]
                                           : cp_w[i][7:0];
              CH_HIGH: rd_d[7:0] = reload_register_select_q ? arl_q[i][15:8]
                                           : cp_w[i][15:8];
              default: rd_d[7:0] = 8'h00;
            endcase
          end
        end
      end
    endcase
  end

  // One wait-free answer; unmapped addresses read as zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_rd;
      if (bus_rd) wb_dat_o <= rd_d;
    end
  end

endmodule

// ### sim/cca_sva.sv
/* Checker for the counter array top ports.
   Assumes a one-cycle registered Wishbone ack and a bind from this file. */
`timescale 1ns/1ns
module cca_sva #(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              nrst,
  // Wishbone
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Pins and request
  input wire logic [NUM_CH-1:0] module_io_out,
  input wire logic [NUM_CH-1:0] module_io_oe_n,
  input wire logic              irq_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hF0 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_dat_hold: assert property (!wb_ack_o && $past(nrst) |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_reset_idle: assert property (
    $rose(nrst) |-> !irq_request && !wb_ack_o && (&module_io_oe_n) && module_io_out == '0)
    else $error("outputs active after reset");
  a_mode_drive: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h20
    |-> ##2 module_io_oe_n[0] == $past(~(wb_dat_i[2] | wb_dat_i[1]), 2))
    else $error("pin drive enable does not follow mode");
endmodule

bind counter_array_capture_compare cca_sva #(.NUM_CH(NUM_CH)) cca_sva_inst (
  .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .module_io_out(module_io_out),
  .module_io_oe_n(module_io_oe_n), .irq_request(irq_request));

// ### sim/pin_model.sv
/* Outside circuitry on the three module pins.
   Assumes the testbench requests levels; drive enables are active low. */
`timescale 1ns/1ns
module pin_model (
  // Clock
  input  wire logic       ref_clk,
  // Requested outside levels
  input  wire logic [2:0] ext_lvl,
  // Module side
  input  wire logic [2:0] module_io_out,
  input  wire logic [2:0] module_io_oe_n,
  output logic      [2:0] module_io_in
);
  logic [2:0] lvl_q  = 3'h0;
  logic [1:0] hold_q = 2'h0;

  // A closer request waits, so no level is shorter than two clocks
  always_ff @(posedge ref_clk) begin
    if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else if (ext_lvl != lvl_q) begin
      lvl_q  <= ext_lvl;
      hold_q <= 2'h2;
    end
  end

  assign module_io_in = (module_io_oe_n & lvl_q) | (~module_io_oe_n & module_io_out);
endmodule

// ### sim/counter_array_capture_compare_tb.sv
/* Directed test of the counter array over Wishbone.
   Assumes the pin model on the far side and the bound checker. */
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module counter_array_capture_compare_tb;
  import cca_pkg::*;
  logic        ref_clk    = 1'b0;
  logic        nrst       = 1'b0;
  logic        wb_cyc_i   = 1'b0;
  logic        wb_stb_i   = 1'b0;
  logic        wb_we_i    = 1'b0;
  logic [7:0]  wb_adr_i   = 8'h00;
  logic [3:0]  wb_sel_i   = 4'h1;
  logic [31:0] wb_dat_i   = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  ext_lvl    = 3'h0;
  logic [2:0]  module_io_in;
  logic [2:0]  module_io_out;
  logic [2:0]  module_io_oe_n;
  logic        irq_request;
  logic        cpu_irq_on = 1'b1; // Global and array enables
  int          bad_count  = 0;
  int          total_checks = 0;

  always #5 ref_clk = ~ref_clk;

  counter_array_capture_compare #(.NUM_CH(3)) counter_array_capture_compare_inst (
    .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer0_ovf_tick(1'b0),
    .ext_osc_tick(1'b0), .rtc_osc_tick(1'b0), .external_count_input(1'b0),
    .module_io_in(module_io_in), .module_io_out(module_io_out),
    .module_io_oe_n(module_io_oe_n), .irq_request(irq_request));

  pin_model pin_model_inst (.ref_clk(ref_clk), .ext_lvl(ext_lvl),
    .module_io_out(module_io_out), .module_io_oe_n(module_io_oe_n),
    .module_io_in(module_io_in));

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] rd_v);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd_v = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] x;
    bus(1'b1, a, v, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus(1'b0, a, 8'h00, v);
  endtask

  // Stop, clear flags, load the counter, run again
  task automatic start(input logic [15:0] s);
    wr(A_CTRL, 8'h00);
    wr(A_CNTL, s[7:0]);
    wr(A_CNTH, s[15:8]);
    wr(A_CTRL, 8'h10);
  endtask

  function automatic logic [7:0] ch(input int n, input logic [3:0] off);
    return {CH_BASE + 4'(n), off};
  endfunction

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [7:0]  d;
    logic [15:0] s;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(A_CTRL, d); `CHK(d, RST_BYTE)
    rd(ch(0, CH_MODE), d); `CHK(d, RST_BYTE)
    rd(8'hF0, d); `CHK(d, 8'h00)
    `CHK(module_io_oe_n, 3'h7)
    wr(ch(1, CH_MODE), 8'h48);
    wr(ch(1, CH_LOW), 8'h10);
    rd(ch(1, CH_MODE), d); `CHK(d, 8'h08)
    wr(ch(1, CH_HIGH), 8'h00);
    rd(ch(1, CH_MODE), d); `CHK(d, 8'h48)
    wr(A_PWMC, 8'h80);
    wr(ch(1, CH_LOW), 8'h55);
    wr(ch(1, CH_HIGH), 8'h66);
    rd(ch(1, CH_LOW), d); `CHK(d, 8'h55)
    wr(A_PWMC, 8'h00);
    rd(ch(1, CH_LOW), d); `CHK(d, 8'h10)
    wr(A_MODE, {4'h0, TB_SYS, 1'b0});
    start(16'h000C);
    repeat (20) @(posedge ref_clk);
    rd(A_CTRL, d); `CHK(d[2:0], 3'h2)
    `CHK(irq_request, 1'b0)
    wr(A_CTRL, 8'h00);
    // Capture on both edges of pin 0, counter stopped
    wr(ch(0, CH_MODE), 8'h31);
    wr(A_CNTL, 8'h34);
    wr(A_CNTH, 8'h12);
    ext_lvl <= 3'h1;
    repeat (8) @(posedge ref_clk);
    rd(ch(0, CH_LOW), d); `CHK(d, 8'h34)
    rd(ch(0, CH_HIGH), d); `CHK(d, 8'h12)
    rd(A_PINS, d); `CHK(d[0], 1'b1)
    `CHK(irq_request & cpu_irq_on, 1'b1)
    rd(A_CTRL, d); `CHK(d[2:0], 3'h1)
    wr(A_CTRL, 8'h00);
    wr(A_CNTL, 8'h78);
    ext_lvl <= 3'h0;
    repeat (8) @(posedge ref_clk);
    rd(ch(0, CH_LOW), d); `CHK(d, 8'h78)
    rd(A_PINS, d); `CHK(d[0], 1'b0)
    // Overflow flags for every cycle length with a wrap, without one at 9-11 bits, and a full counter wrap at 8 bits
    wr(A_MODE, {4'h0, TB_SYS, 1'b1});
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        s = 16'((32'h1 << (8 + k)) - 32'd2 - 32'(256 * j));
        wr(A_PWMC, 8'(k));
        start(s);
        repeat (6) @(posedge ref_clk);
        rd(A_CTRL, d); `CHK(d[7:6], {k == 0 && j == 1, j == 0 || k == 0})
        `CHK(irq_request, 1'(k == 0 && j == 1))
      end
    end
    wr(A_MODE, {4'h0, TB_SYS, 1'b0});
    wr(A_PWMC, 8'h00);
    // High-speed toggle on pin 2, then comparator off
    wr(ch(2, CH_MODE), 8'h4C);
    wr(ch(2, CH_LOW), 8'h40);
    wr(ch(2, CH_HIGH), 8'h00);
    start(16'h003C);
    repeat (12) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b1)
    rd(A_CTRL, d); `CHK(d[2], 1'b1)
    wr(ch(2, CH_LOW), 8'h40);
    start(16'h003C);
    repeat (12) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b1)
    // 8-bit PWM: low 0x80 reloaded to 0xC0 at first wrap, so first match at 0xC0
    wr(ch(2, CH_MODE), 8'h4A);
    wr(ch(2, CH_LOW), 8'h80);
    wr(ch(2, CH_HIGH), 8'hC0);
    start(16'h00F0);
    repeat (176) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b0)
    repeat (64) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b1)
    rd(A_CTRL, d); `CHK(d[6] & d[2], 1'b1)
    repeat (64) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b0)
    wr(ch(2, CH_LOW), 8'h00);
    repeat (416) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b0)
    // Frequency output on pin 2: step 8 from 0x10, no match flag
    wr(A_CTRL, 8'h00);
    wr(ch(2, CH_MODE), 8'h46);
    wr(ch(2, CH_LOW), 8'h10);
    wr(ch(2, CH_HIGH), 8'h08);
    start(16'h0000);
    repeat (20) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b1)
    repeat (8) @(posedge ref_clk);
    `CHK(module_io_out[2], 1'b0)
    rd(ch(2, CH_LOW), d); `CHK(d, 8'h20)
    rd(A_CTRL, d); `CHK(d[2], 1'b0)
    close_out();
  end
endmodule
